// [design/sspms_top.sv]
// synchronous half-duplex serial port with apb register access
`timescale 1ns/10ps
module sspms_top
  import sspms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_pin_in,
  output logic clock_pin_out,
  output logic clock_pin_oe_n,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe_n
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [7:0] tx_status_control; // writable transmit controls
  logic [7:0] rx_status_control; // writable receive controls
  logic [7:0] baud_control; // polarity and width select
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic [7:0] tx_data_reg; // pending transmit byte
  logic tx_ninth_pend; // ninth bit captured with the byte
  logic tx_buf_full; // pending byte waiting
  logic overrun_flag;
  logic ovr_single; // overrun raised in single mode
  // engine state
  sspms_state_t state;
  logic [8:0] tx_shift_reg;
  logic [8:0] rx_shift_reg;
  logic [3:0] bit_cnt;
  logic phase; // master: 0 before leading, 1 before trailing
  logic [15:0] div_cnt;
  logic [1:0] pre_cnt;
  // receive fifo
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] fifo_cnt;
  // pin synchronisers
  logic ck_s1, ck_s2, ck_s3;
  logic dt_s1, dt_s2;
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire acc = psel & penable;
  wire setup = psel & ~penable;
  wire wr = acc & pwrite;
  wire sel_txs = paddr == REG_TX_STATUS;
  wire sel_rxs = paddr == REG_RX_STATUS;
  wire sel_bdc = paddr == REG_BAUD_CTL;
  wire sel_dlo = paddr == REG_DIV_LOW;
  wire sel_dhi = paddr == REG_DIV_HIGH;
  wire sel_txd = paddr == REG_TX_DATA;
  wire sel_rxd = paddr == REG_RX_DATA;
  wire sel_sta = paddr == REG_PORT_STAT;
  wire mapped = sel_txs | sel_rxs | sel_bdc | sel_dlo | sel_dhi
              | sel_txd | sel_rxd | sel_sta;
  wire wr_rxs = wr & sel_rxs;
  wire wr_txd = wr & sel_txd;
  wire rd_rxd = acc & ~pwrite & sel_rxd;
  // control bit aliases
  wire port_enable = rx_status_control[RCS_PEN];
  wire rx_nine_bit_en = rx_status_control[RCS_NINE];
  wire single_receive_en = rx_status_control[RCS_SINGLE];
  wire continuous_receive_en = rx_status_control[RCS_CONT];
  wire master_clock_source = tx_status_control[TXS_MCS];
  wire tx_nine_bit_en = tx_status_control[TXS_NINE];
  wire transmit_enable = tx_status_control[TXS_TRANSMIT_ENABLE];
  wire baud_high_speed = tx_status_control[TXS_HS];
  wire tx_ninth_bit = tx_status_control[TXS_T9];
  wire clock_idle_high = baud_control[BDC_CPOL];
  wire baud_wide_sel = baud_control[BDC_WIDE];
  // ------------------------------------------------------------
  // mode selection
  // ------------------------------------------------------------
  wire active = port_enable & tx_status_control[TXS_SYNC];
  wire master = active & master_clock_source;
  wire slave = active & ~master_clock_source;
  wire rx_cfg = single_receive_en | continuous_receive_en;
  wire tx_cfg = active & ~rx_cfg & transmit_enable;
  // ------------------------------------------------------------
  // baud generator: divisor picked by width select, low speed
  // stretches each half period by a prescale of four
  // ------------------------------------------------------------
  wire [15:0] divisor = baud_wide_sel ? {baud_divisor_high, baud_divisor_low}
                                      : {8'h00, baud_divisor_low};
  wire run = master & (state != ST_IDLE);
  wire div_hit = div_cnt == divisor;
  wire half_tick = run & div_hit
                 & (baud_high_speed | pre_cnt == LOW_SPEED_PRE);
  // ------------------------------------------------------------
  // clock edge events for both master and slave
  // ------------------------------------------------------------
  wire s_edge = ck_s2 != ck_s3;
  wire s_lead = slave & s_edge & (ck_s3 == clock_idle_high);
  wire s_trail = slave & s_edge & (ck_s2 == clock_idle_high);
  wire lead = master ? (half_tick & ~phase) : s_lead;
  wire trail = master ? (half_tick & phase) : s_trail;
  wire [3:0] last_bit = (state == ST_RX)
                      ? (rx_nine_bit_en ? LAST_BIT9 : LAST_BIT8)
                      : (tx_nine_bit_en ? LAST_BIT9 : LAST_BIT8);
  wire at_last = bit_cnt == last_bit;
  wire start_tx = (state == ST_IDLE) & tx_cfg & tx_buf_full;
  wire start_rx = (state == ST_IDLE) & active & rx_cfg & ~overrun_flag;
  wire rx_abort = (state == ST_RX) & (~rx_cfg | overrun_flag);
  wire tx_abort = (state == ST_TX) & ~tx_cfg;
  wire rx_done = (state == ST_RX) & ~rx_abort & trail & at_last;
  wire tx_done = (state == ST_TX) & ~tx_abort & trail & at_last;
  wire tsr_load = start_tx | (tx_done & tx_buf_full);
  wire keep_rx = continuous_receive_en | slave;
  wire clr_single = rx_done & master;
  // ------------------------------------------------------------
  // received character and fifo control
  // ------------------------------------------------------------
  wire [8:0] shifted = {dt_s2, rx_shift_reg[8:1]};
  wire [8:0] rx_char = rx_nine_bit_en ? shifted
                                      : {1'b0, shifted[8:1]};
  wire fifo_full = fifo_cnt == 2'(FIFO_DEPTH);
  wire push = rx_done & ~fifo_full & ~overrun_flag;
  wire ovr_set = rx_done & fifo_full;
  wire pop = rd_rxd & (fifo_cnt != 2'h0);
  wire rx_char_avail_flag = fifo_cnt != 2'h0;
  // an empty fifo reads as zero so that stale or unwritten storage never leaks out
  wire [8:0] head = rx_char_avail_flag ? fifo_mem[rd_ptr] : 9'h000;
  wire ovr_clear = ovr_single ? rd_rxd : ~continuous_receive_en;
  wire [1:0] next_fifo_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};
  // ------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------
  wire [7:0] txs_rd = {tx_status_control[7:4], 1'b0,
                       baud_high_speed, state != ST_TX, tx_ninth_bit};
  wire [7:0] rxs_rd = {rx_status_control[7:4], 2'b00,
                       overrun_flag, head[8]};
  wire [7:0] rd_byte = sel_txs ? txs_rd
                     : sel_rxs ? rxs_rd
                     : sel_bdc ? {3'b000, clock_idle_high, baud_wide_sel, 3'b000}
                     : sel_dlo ? baud_divisor_low
                     : sel_dhi ? baud_divisor_high
                     : sel_rxd ? head[7:0]
                     : sel_sta ? {6'h00, tx_buf_full, rx_char_avail_flag}
                     : 8'h00;
  // ------------------------------------------------------------
  // apb answer: zero wait, data captured in setup
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= {24'h000000, rd_byte};
        pslverr <= ~mapped;
      end
    end
  end
  // ------------------------------------------------------------
  // software controls; a write beats the hardware clear
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_status_control <= CTL_RST;
      baud_control <= CTL_RST;
      baud_divisor_low <= CTL_RST;
      baud_divisor_high <= CTL_RST;
    end else if (wr) begin
      if (sel_txs) tx_status_control <= pwdata[7:0];
      if (sel_bdc) baud_control <= pwdata[7:0];
      if (sel_dlo) baud_divisor_low <= pwdata[7:0];
      if (sel_dhi) baud_divisor_high <= pwdata[7:0];
    end
  end
  // receive controls; single enable self-clears after a character in master mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_status_control <= CTL_RST;
    end else if (wr_rxs) begin
      rx_status_control <= pwdata[7:0];
    end else if (clr_single) begin
      rx_status_control[RCS_SINGLE] <= 1'b0;
    end
  end
  // transmit holding byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_reg <= 8'h00;
      tx_ninth_pend <= 1'b0;
      tx_buf_full <= 1'b0;
    end else if (!port_enable) begin
      tx_buf_full <= 1'b0;
    end else if (wr_txd) begin
      tx_data_reg <= pwdata[7:0];
      tx_ninth_pend <= tx_ninth_bit;
      tx_buf_full <= 1'b1;
    end else if (tsr_load) begin
      tx_buf_full <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end else begin
      ck_s1 <= clock_pin_in;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= data_pin_in;
      dt_s2 <= dt_s1;
    end
  end
  // ------------------------------------------------------------
  // baud counters, held clear while the master is idle
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      pre_cnt <= 2'h0;
    end else if (!run) begin
      div_cnt <= 16'h0000;
      pre_cnt <= 2'h0;
    end else if (div_hit) begin
      div_cnt <= 16'h0000;
      pre_cnt <= pre_cnt + 2'h1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // shift engine; data changes on leading, sampled on trailing
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      tx_shift_reg <= 9'h000;
      rx_shift_reg <= 9'h000;
      bit_cnt <= 4'h0;
      phase <= 1'b0;
      clock_pin_out <= 1'b0;
      data_pin_out <= 1'b0;
    end else if (!port_enable) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      phase <= 1'b0;
      clock_pin_out <= clock_idle_high;
    end else begin
      unique case (state)
        ST_IDLE: begin
          bit_cnt <= 4'h0;
          phase <= 1'b0;
          clock_pin_out <= clock_idle_high;
          if (start_tx) begin
            state <= ST_TX;
            tx_shift_reg <= {tx_ninth_pend, tx_data_reg};
          end else if (start_rx) begin
            state <= ST_RX;
          end
        end
        ST_TX: begin
          if (tx_abort) begin
            state <= ST_IDLE;
          end else if (lead) begin
            phase <= 1'b1;
            clock_pin_out <= ~clock_idle_high;
            data_pin_out <= tx_shift_reg[0];
          end else if (trail) begin
            phase <= 1'b0;
            clock_pin_out <= clock_idle_high;
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (at_last) begin
              bit_cnt <= 4'h0;
              if (tx_buf_full) begin
                tx_shift_reg <= {tx_ninth_pend, tx_data_reg};
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_RX: begin
          if (rx_abort) begin
            state <= ST_IDLE;
            clock_pin_out <= clock_idle_high;
          end else if (lead) begin
            phase <= 1'b1;
            clock_pin_out <= ~clock_idle_high;
          end else if (trail) begin
            phase <= 1'b0;
            clock_pin_out <= clock_idle_high;
            rx_shift_reg <= shifted;
            bit_cnt <= bit_cnt + 4'h1;
            if (at_last) begin
              bit_cnt <= 4'h0;
              if (!keep_rx) state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // pin drivers: enables low while driving
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_pin_oe_n <= 1'b1;
      data_pin_oe_n <= 1'b1;
    end else begin
      clock_pin_oe_n <= ~master;
      data_pin_oe_n <= ~tx_cfg;
    end
  end
  // ------------------------------------------------------------
  // receive fifo, two entries
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fifo_cnt <= 2'h0;
    end else if (!port_enable) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      fifo_cnt <= next_fifo_cnt;
    end
  end
  // storage, no reset needed
  always_ff @(posedge pclk) begin
    if (push) fifo_mem[wr_ptr] <= rx_char;
  end
  // overrun: a new overrun wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_flag <= 1'b0;
      ovr_single <= 1'b0;
    end else if (!port_enable) begin
      overrun_flag <= 1'b0;
    end else if (ovr_set) begin
      overrun_flag <= 1'b1;
      ovr_single <= single_receive_en & ~continuous_receive_en;
    end else if (ovr_clear) begin
      overrun_flag <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_SINGLE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done & master & ~wr_rxs) |=> !rx_status_control[RCS_SINGLE])
    else $error("single receive not cleared after character");
  AST_SINGLE_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done & master & ~continuous_receive_en) |=> state == ST_IDLE [*2])
    else $error("single receive kept clocking");
  AST_BOTH_CONTINUE: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done & master & continuous_receive_en & ~wr_rxs & ~fifo_full)
    |=> state == ST_RX && !single_receive_en)
    else $error("continuous receive did not take over");
  AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RX && $fell(continuous_receive_en) && !single_receive_en)
    |=> state == ST_IDLE && fifo_cnt == $past(fifo_cnt))
    else $error("partial character not discarded");
  AST_RX_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    (active & rx_cfg) |=> data_pin_oe_n)
    else $error("data pin driven while receiving");
  AST_SLAVE_CLK: assert property (@(posedge pclk) disable iff (!presetn)
    slave |=> clock_pin_oe_n)
    else $error("clock pin driven in slave mode");
  AST_AVAIL: assert property (@(posedge pclk) disable iff (!presetn)
    (push & ~pop & port_enable) |=> rx_char_avail_flag [*1] ##0 fifo_cnt != 2'h0)
    else $error("available flag missing after push");
  AST_OVR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (overrun_flag & ~pop & port_enable) |=> fifo_cnt == $past(fifo_cnt))
    else $error("fifo changed during overrun");
  AST_OVR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done & fifo_full & port_enable) |=> overrun_flag && fifo_cnt == 2'h2)
    else $error("overrun not raised on third character");
  AST_OVR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (overrun_flag & ovr_single & rd_rxd & ~ovr_set) |=> !overrun_flag)
    else $error("single mode overrun not cleared by read");
  AST_TX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_TX & tx_buf_full & ~trail & ~tx_abort & port_enable)
    |=> tx_buf_full)
    else $error("transmit byte left buffer while shift busy");
endmodule

// [design/sspms_pkg.sv]
// constants, types and register map of the synchronous serial port
package sspms_pkg;
  // ------------------------------------------------------------
  // register byte addresses on the bus
  // ------------------------------------------------------------
  localparam logic [7:0] REG_TX_STATUS = 8'h00;
  localparam logic [7:0] REG_RX_STATUS = 8'h04;
  localparam logic [7:0] REG_BAUD_CTL = 8'h08;
  localparam logic [7:0] REG_DIV_LOW = 8'h0C;
  localparam logic [7:0] REG_DIV_HIGH = 8'h10;
  localparam logic [7:0] REG_TX_DATA = 8'h14;
  localparam logic [7:0] REG_RX_DATA = 8'h18;
  localparam logic [7:0] REG_PORT_STAT = 8'h1C;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TXS_MCS = 7;
  localparam int TXS_NINE = 6;
  localparam int TXS_TRANSMIT_ENABLE = 5;
  localparam int TXS_SYNC = 4;
  localparam int TXS_HS = 2;
  localparam int TXS_T9 = 0;
  localparam int RCS_PEN = 7;
  localparam int RCS_NINE = 6;
  localparam int RCS_SINGLE = 5;
  localparam int RCS_CONT = 4;
  localparam int BDC_CPOL = 4;
  localparam int BDC_WIDE = 3;
  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam logic [1:0] LOW_SPEED_PRE = 2'h3;
  localparam int FIFO_DEPTH = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} sspms_state_t;
endpackage

// [verification/sspms_remote.sv]
// remote synchronous serial device model that faces the port's pins
`timescale 1ns/10ps
module sspms_remote (
  input wire logic clk_wire,
  input wire logic data_wire,
  output logic clk_drv,
  output logic data_drv
);
  logic [8:0] tx_word = 9'h000; // character presented, lsb first
  logic [8:0] rx_word = 9'h000; // bits seen on trailing edges
  int nbits = 8; // bits per character
  int bitn = 0; // next bit to present
  int rx_cnt = 0; // trailing edges seen
  initial begin
    clk_drv = 1'b0;
    data_drv = 1'b0;
  end
  // present the next bit on each leading (rising) edge
  always @(posedge clk_wire) begin
    data_drv <= tx_word[bitn];
    bitn <= (bitn + 1) % nbits;
  end
  // capture on trailing edge; once hold ends the line no longer keeps the bit
  always @(negedge clk_wire) begin
    rx_word <= {data_wire, rx_word[8:1]};
    rx_cnt <= rx_cnt + 1;
    #25 data_drv <= ~data_drv;
  end
  // clock master: one clock per data bit, clock stands low between frames
  task automatic send(input logic [8:0] val, input int n);
    tx_word = val;
    bitn = 0;
    nbits = n;
    for (int i = 0; i < n; i++) begin
      clk_drv = 1'b1;
      #62.5;
      clk_drv = 1'b0;
      #62.5;
    end
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench of the synchronous serial port
`timescale 1ns/10ps
module tb_top;
  import sspms_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ck_out, ck_oe_n, dt_out, dt_oe_n, clk_drv, data_drv;
  wire clk_wire = ck_oe_n ? clk_drv : ck_out; // resolved clock line
  wire data_wire = dt_oe_n ? data_drv : dt_out; // resolved data line
  int err_count = 0;
  int n_tests = 0;
  sspms_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_pin_in(clk_wire), .clock_pin_out(ck_out),
    .clock_pin_oe_n(ck_oe_n), .data_pin_in(data_wire), .data_pin_out(dt_out),
    .data_pin_oe_n(dt_oe_n));
  sspms_remote rem_u (.clk_wire(clk_wire), .data_wire(data_wire), .clk_drv(clk_drv),
    .data_drv(data_drv));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 20) begin
        err_count++;
        print_verdict();
      end
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk8(rd[7:0], exp);
  endtask
  // bounded poll of a register until a masked bit is set
  task automatic poll(input logic [7:0] a, input logic [7:0] mask);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, a, 8'h00);
      if ((rd[7:0] & mask) !== 8'h00) return;
    end
    err_count++;
    print_verdict();
  endtask
  task automatic wait_bits(input int n);
    for (int i = 0; i < 5000; i++) begin
      @(posedge pclk);
      if (rem_u.rx_cnt >= n) return;
    end
    err_count++;
    print_verdict();
  endtask
  // ------------------------------------------------------------
  // clock, reset and scenarios
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(REG_TX_STATUS, 8'h02);
    rdchk(REG_RX_STATUS, 8'h00);
    chk1(ck_oe_n, 1'b1);
    apb(1'b0, 8'h40, 8'h00);
    chk1(perr, 1'b1);
    // master transmit, second byte waits behind the first
    apb(1'b1, REG_DIV_LOW, 8'h03);
    rdchk(REG_DIV_LOW, 8'h03);
    apb(1'b1, REG_RX_STATUS, 8'h80);
    apb(1'b1, REG_TX_STATUS, 8'hB4);
    rem_u.rx_cnt = 0;
    apb(1'b1, REG_TX_DATA, 8'hA5);
    apb(1'b1, REG_TX_DATA, 8'h3C);
    chk1(ck_oe_n, 1'b0);
    chk1(dt_oe_n, 1'b0);
    wait_bits(8);
    chk8(rem_u.rx_word[8:1], 8'hA5);
    wait_bits(16);
    chk8(rem_u.rx_word[8:1], 8'h3C);
    // nine-bit transmit: ninth bit set before the low byte is written
    apb(1'b1, REG_TX_STATUS, 8'hF5);
    rem_u.rx_cnt = 0;
    apb(1'b1, REG_TX_DATA, 8'h5A);
    wait_bits(9);
    chk8(rem_u.rx_word[7:0], 8'h5A);
    chk1(rem_u.rx_word[8], 1'b1);
    repeat (20) @(posedge pclk);
    chk1(ck_out, 1'b0);
    apb(1'b1, REG_BAUD_CTL, 8'h10);
    repeat (4) @(posedge pclk);
    chk1(ck_out, 1'b1);
    apb(1'b1, REG_BAUD_CTL, 8'h00);
    // master single receive
    apb(1'b1, REG_TX_STATUS, 8'h94);
    rem_u.tx_word = 9'h05A;
    rem_u.bitn = 0;
    apb(1'b1, REG_RX_STATUS, 8'hA0);
    repeat (3) @(posedge pclk);
    chk1(dt_oe_n, 1'b1);
    poll(REG_PORT_STAT, 8'h01);
    rdchk(REG_RX_STATUS, 8'h80);
    rdchk(REG_RX_DATA, 8'h5A);
    rdchk(REG_PORT_STAT, 8'h00);
    // both enables, nine bits, run into overrun
    rem_u.tx_word = 9'h1C3;
    rem_u.bitn = 0;
    rem_u.nbits = 9;
    apb(1'b1, REG_RX_STATUS, 8'hF0);
    poll(REG_RX_STATUS, 8'h02);
    chk8(rd[7:0], 8'hD3);
    rdchk(REG_RX_DATA, 8'hC3);
    rdchk(REG_RX_STATUS, 8'hD3);
    apb(1'b1, REG_RX_STATUS, 8'hC0);
    rdchk(REG_RX_STATUS, 8'hC1);
    rdchk(REG_RX_DATA, 8'hC3);
    rdchk(REG_PORT_STAT, 8'h00);
    chk1(ck_out, 1'b0);
    // slave receive from the remote clock master
    apb(1'b1, REG_RX_STATUS, 8'h00);
    apb(1'b1, REG_TX_STATUS, 8'h10);
    apb(1'b1, REG_RX_STATUS, 8'h90);
    repeat (3) @(posedge pclk);
    chk1(ck_oe_n, 1'b1);
    chk1(dt_oe_n, 1'b1);
    rem_u.send(9'h096, 8);
    poll(REG_PORT_STAT, 8'h01);
    rdchk(REG_RX_DATA, 8'h96);
    print_verdict();
  end
endmodule
